/* File: logic/dpw_pkg.sv */
// Package: constants and types for the digital potentiometer serial wiper load block
// Summary of operation
// - While select is low, shift serial data in on each rising serial clock edge.
// - More than eight bits in one frame: keep only the last eight.
// - Each rising select edge copies the shift register into the wiper register.
// - The copy happens even when no bits arrived since the last one.
// - Reset clears the shift register and presets the wiper to 0x80.
// - Wiper stays midscale until first select rise; empty frame reloads the held shift register, 0x00 after reset.
// - Wiper code D selects exactly one of 256 taps, D steps above bottom.
// - Code 0x00 connects the wiper straight to the bottom terminal.
// - Top code selects tap one step below top; top terminal never selected.
// - Bottom-side steps rise and top-side steps fall with code, complementary.
package dpw_pkg;
   localparam int          WORD_W      = 8;
   localparam int          TAP_N       = 256;
   localparam logic [7:0]  SHIFT_RST   = 8'h00;
   localparam logic [7:0]  WIPER_RST   = 8'h80;
   localparam int          SYNC_STAGES = 2;

   // Sampled serial pins after synchronisation
   typedef struct packed {
      logic select_n;
      logic sclk;
      logic sdata;
   } dpw_pins_t;

   // Tap decode result: one-hot taps and complementary step counts
   typedef struct packed {
      logic [255:0] tap_onehot;
      logic [8:0]   steps_to_bottom;
      logic [8:0]   steps_to_top;
   } dpw_tap_t;
endpackage

/* File: logic/dpw_serial_wiper.sv */
// Module: three-wire serial front end that loads the potentiometer wiper register
`timescale 1ns/10ps
module dpw_serial_wiper (
   input  wire logic               sys_clk,          // System clock, 125 MHz
   input  wire logic               reset_n,          // Synchronous reset, active low
   input  wire logic               clk_en,           // Clock enable, freezes state when low
   input  wire logic               select_n_pin,     // Serial select pin, active low
   input  wire logic               sclk_pin,         // Serial clock pin
   input  wire logic               serial_in_pin,    // Serial data pin
   output logic [7:0]              wiper_code,       // Current wiper register
   output logic [255:0]            tap_select,       // One-hot tap select
   output logic [8:0]              wiper_to_bottom_resistance, // Steps wiper to bottom
   output logic [8:0]              wiper_to_top_resistance,    // Steps wiper to top
   output logic                    load_done         // Pulse after a wiper load
);
   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   dpw_pkg::dpw_pins_t meta_q;
   dpw_pkg::dpw_pins_t sync_q;
   dpw_pkg::dpw_pins_t prev_q;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         meta_q <= 3'h7;
         sync_q <= 3'h7;
         prev_q <= 3'h7;
      end else if (clk_en) begin
         meta_q <= '{select_n: select_n_pin, sclk: sclk_pin, sdata: serial_in_pin};
         sync_q <= meta_q;
         prev_q <= sync_q;
      end
   end

   // ----------------------------------------------------------------
   // Edge detection
   // ----------------------------------------------------------------
   // Third flop only remembers the last synchronised level, never feeds logic alone
   wire sclk_rise   = sync_q.sclk & ~prev_q.sclk;
   wire select_rise = sync_q.select_n & ~prev_q.select_n;
   // Sample with the select level seen alongside the clock edge
   wire shift_en    = sclk_rise & ~sync_q.select_n;

   // ----------------------------------------------------------------
   // Shift and wiper registers
   // ----------------------------------------------------------------
   logic [7:0] shift_q;
   logic [7:0] shift_d;
   logic [7:0] wiper_q;
   logic [7:0] wiper_d;
   logic       done_q;

   // Shifting left drops the oldest bit, so only the last eight survive
   assign shift_d = shift_en ? {shift_q[6:0], sync_q.sdata} : shift_q;
   // Load the register as it stands, even if no bits were shifted
   assign wiper_d = select_rise ? shift_q : wiper_q;

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         shift_q <= dpw_pkg::SHIFT_RST;
         wiper_q <= dpw_pkg::WIPER_RST;
         done_q  <= 1'b0;
      end else if (clk_en) begin
         shift_q <= shift_d;
         wiper_q <= wiper_d;
         done_q  <= select_rise;
      end
   end

   // ----------------------------------------------------------------
   // Tap decode
   // ----------------------------------------------------------------
   dpw_pkg::dpw_tap_t tap;

   dpw_tap_decode u_decode (
      .code (wiper_q),
      .tap  (tap)
   );

   assign wiper_code                 = wiper_q;
   assign tap_select                 = tap.tap_onehot;
   assign wiper_to_bottom_resistance = tap.steps_to_bottom;
   assign wiper_to_top_resistance    = tap.steps_to_top;
   assign load_done                  = done_q;

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   property p_shift_in;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && shift_en) |=> (shift_q == {$past(shift_q[6:0]), $past(sync_q.sdata)});
   endproperty
   a_shift_in: assert property (p_shift_in) else $error("shift missed a bit");

   property p_hold_idle;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && sync_q.select_n) |=> (shift_q == $past(shift_q));
   endproperty
   a_hold_idle: assert property (p_hold_idle) else $error("shift moved with select high");

   property p_load;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && select_rise) |=> (wiper_q == $past(shift_q)) && load_done;
   endproperty
   a_load: assert property (p_load) else $error("wiper not loaded on select rise");

   property p_load_always;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && select_rise && !shift_en) |=> (wiper_q == $past(shift_q));
   endproperty
   a_load_always: assert property (p_load_always) else $error("idle frame not loaded");

   property p_wiper_stable;
      @(posedge sys_clk) disable iff (!reset_n)
      !select_rise |=> $stable(wiper_q);
   endproperty
   a_wiper_stable: assert property (p_wiper_stable) else $error("wiper moved without select");

   property p_reset_vals;
      @(posedge sys_clk) !reset_n |=> (wiper_q == 8'h80) && (shift_q == 8'h00);
   endproperty
   a_reset_vals: assert property (p_reset_vals) else $error("bad reset values");

   property p_onehot;
      @(posedge sys_clk) disable iff (!reset_n)
      $onehot(tap_select) && tap_select[wiper_q];
   endproperty
   a_onehot: assert property (p_onehot) else $error("tap select not one-hot");

   property p_bottom;
      @(posedge sys_clk) disable iff (!reset_n)
      (wiper_q == 8'h00) |-> tap_select[0] && (wiper_to_bottom_resistance == 9'h000);
   endproperty
   a_bottom: assert property (p_bottom) else $error("zero code not at bottom");

   property p_top;
      @(posedge sys_clk) disable iff (!reset_n)
      wiper_to_top_resistance != 9'h000;
   endproperty
   a_top: assert property (p_top) else $error("top terminal selected");

   property p_compl;
      @(posedge sys_clk) disable iff (!reset_n)
      (wiper_to_bottom_resistance + wiper_to_top_resistance) == 9'h100;
   endproperty
   a_compl: assert property (p_compl) else $error("steps not complementary");

   // ----------------------------------------------------------------
   // Pin path, enable and pulse checks
   // ----------------------------------------------------------------
   // Second stage must copy the first, so a pin level is never skipped
   property p_sync_chain;
      @(posedge sys_clk) disable iff (!reset_n)
      clk_en |=> (sync_q == $past(meta_q));
   endproperty
   a_sync_chain: assert property (p_sync_chain) else $error("sync stage skipped");

   property p_sclk_ignored;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && sclk_rise && sync_q.select_n) |=> $stable(shift_q);
   endproperty
   a_sclk_ignored: assert property (p_sclk_ignored) else $error("clock edge taken deselected");

   property p_done_only;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && !select_rise) |=> !load_done;
   endproperty
   a_done_only: assert property (p_done_only) else $error("load pulse without select rise");

   // A frozen cycle must leave wiper, shift, done and the second sync stage untouched
   property p_freeze;
      @(posedge sys_clk) disable iff (!reset_n)
      !clk_en |=> $stable(wiper_q) && $stable(shift_q) && $stable(done_q) && $stable(sync_q);
   endproperty
   a_freeze: assert property (p_freeze) else $error("state moved with enable low");

   property p_monotonic;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && select_rise && (shift_q > wiper_q))
         |=> (wiper_to_bottom_resistance > $past(wiper_to_bottom_resistance));
   endproperty
   a_monotonic: assert property (p_monotonic) else $error("bottom steps not rising");

   property p_top_code;
      @(posedge sys_clk) disable iff (!reset_n)
      (wiper_q == 8'hff) |-> tap_select[255] && (wiper_to_top_resistance == 9'h001);
   endproperty
   a_top_code: assert property (p_top_code) else $error("top code not one step below");

   property p_reset_done;
      @(posedge sys_clk) !reset_n |=> !load_done;
   endproperty
   a_reset_done: assert property (p_reset_done) else $error("load pulse during reset");

   // Empty frame after reset must land on the bottom terminal
   property p_zero_frame;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && select_rise && (shift_q == 8'h00)) |=> tap_select[0];
   endproperty
   a_zero_frame: assert property (p_zero_frame) else $error("empty frame not at bottom");

   property p_wiper_reach;
      @(posedge sys_clk) disable iff (!reset_n)
      (clk_en && select_rise) |=> tap_select[$past(shift_q)];
   endproperty
   a_wiper_reach: assert property (p_wiper_reach) else $error("loaded code not decoded");

   // ----------------------------------------------------------------
   // Coverage of the main scenarios
   // ----------------------------------------------------------------
   c_freeze: cover property (@(posedge sys_clk) disable iff (!reset_n) !clk_en);
   c_load:  cover property (@(posedge sys_clk) disable iff (!reset_n) select_rise);
   c_full:  cover property (@(posedge sys_clk) disable iff (!reset_n) wiper_q == 8'hff);
   c_zero:  cover property (@(posedge sys_clk) disable iff (!reset_n) wiper_q == 8'h00);
   c_shift: cover property (@(posedge sys_clk) disable iff (!reset_n) shift_en);
endmodule

/* File: logic/dpw_tap_decode.sv */
// Module: decodes the wiper code into a one-hot tap select and step counts
`timescale 1ns/10ps
module dpw_tap_decode (
   input  wire logic [7:0]   code,  // Wiper register value
   output dpw_pkg::dpw_tap_t tap    // Decoded tap
);
   genvar i;
   generate
      for (i = 0; i < dpw_pkg::TAP_N; i = i + 1) begin : g_tap
         assign tap.tap_onehot[i] = (code == 8'(i));
      end
   endgenerate

   // Top count is 256 - D, never zero, so the top terminal is unreachable
   assign tap.steps_to_bottom = {1'b0, code};
   assign tap.steps_to_top    = 9'h100 - {1'b0, code};
endmodule

/* File: sim/dpw_master_model.sv */
// Serial master model that drives the select, clock and data pins
`timescale 1ns/10ps
module dpw_master_model (
   input  wire logic        sys_clk,  // Bench clock
   input  wire logic        reset_n,  // Synchronous reset, active low
   input  wire logic        start,    // Begin one frame
   input  wire logic        spin,     // Toggle clock while deselected
   input  wire logic [4:0]  nbits,    // Bits in the frame
   input  wire logic [15:0] word,     // Frame bits, last sent at bit 0
   output logic             select_n, // Select pin, active low
   output logic             sclk,     // Serial clock pin
   output logic             sdata     // Serial data pin
);
   logic [2:0]  ph_q;
   logic [4:0]  left_q;
   logic [15:0] word_q;
   // ----------------------------------------
   // Frame sequencer, 64 ns clock period
   // ----------------------------------------
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         select_n <= 1'b1;
         sclk     <= 1'b1;
         sdata    <= 1'b0;
         ph_q     <= 3'h0;
      end else if (start && select_n) begin
         select_n <= 1'b0;
         ph_q     <= 3'h0;
         left_q   <= nbits;
         word_q   <= word;
      end else if (!select_n || spin) begin
         ph_q <= ph_q + 3'h1;
         if (select_n && ph_q == 3'h3) begin
            sclk  <= ~sclk;
            sdata <= ~sdata;
         end else if (ph_q == 3'h3 && left_q == 5'h00) begin
            select_n <= 1'b1;
            sdata    <= ~sdata; // Released line must not hold the last bit
         end else if (ph_q == 3'h3) begin
            sclk  <= 1'b0;
            sdata <= word_q[left_q - 5'h01];
         end else if (ph_q == 3'h7 && !select_n) begin
            sclk   <= 1'b1;
            left_q <= left_q - 5'h01;
         end
      end
   end
endmodule

/* File: sim/tb_dpw_serial_wiper.sv */
// Testbench for the serial wiper load block
`timescale 1ns/10ps
module tb_dpw_serial_wiper;
   logic         sys_clk = 1'b0;
   logic         reset_n = 1'b0;
   logic         start   = 1'b0;
   logic         spin    = 1'b0;
   logic         clk_en  = 1'b1;
   logic [4:0]   nbits   = 5'h00;
   logic [15:0]  word    = 16'h0000;
   logic         select_n, sclk, sdata, load_done;
   logic [7:0]   wiper_code;
   logic [255:0] tap_select;
   logic [8:0]   to_bot, to_top;
   int           errors = 0;
   int           total_checks = 0;
   always #4 sys_clk = ~sys_clk;
   dpw_master_model dpw_master_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .start(start),
      .spin(spin), .nbits(nbits), .word(word), .select_n(select_n), .sclk(sclk), .sdata(sdata));
   dpw_serial_wiper dpw_serial_wiper_i (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(clk_en),
      .select_n_pin(select_n), .sclk_pin(sclk), .serial_in_pin(sdata),
      .wiper_code(wiper_code), .tap_select(tap_select), .wiper_to_bottom_resistance(to_bot),
      .wiper_to_top_resistance(to_top), .load_done(load_done));
   task automatic test_done();
      $display("errors=%0d checks=%0d", errors, total_checks);
      if (errors == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] exp);
      total_checks++;
      if (wiper_code !== exp || tap_select !== (256'h1 << exp) || to_bot !== {1'b0, exp}
          || to_top !== 9'h100 - {1'b0, exp}) begin
         errors++;
         $display("[FAIL] wiper_code exp %h seen %h steps %h %h", exp, wiper_code, to_bot, to_top);
      end
   endtask
   // ----------------------------------------
   // Scenarios
   // ----------------------------------------
   task automatic frame(input logic [4:0] n, input logic [15:0] w, input logic [7:0] exp);
      int k;
      @(posedge sys_clk);
      start <= 1'b1;
      nbits <= n;
      word  <= w;
      @(posedge sys_clk);
      start <= 1'b0;
      for (k = 0; k < 400 && load_done !== 1'b1; k++) @(negedge sys_clk);
      if (k == 400) begin
         errors++;
         test_done();
      end
      chk(exp);
   endtask
   task automatic sc_reset();
      @(posedge sys_clk);
      reset_n <= 1'b0;
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      repeat (3) @(negedge sys_clk);
      chk(8'h80);
      frame(5'd0, 16'h0000, 8'h00);
   endtask
   task automatic sc_words();
      frame(5'd8, 16'h00a5, 8'ha5);
      frame(5'd12, 16'h0fc9, 8'hc9);
      frame(5'd8, 16'h00ff, 8'hff);
      frame(5'd8, 16'h0001, 8'h01);
   endtask
   task automatic sc_ignored();
      frame(5'd8, 16'h00c9, 8'hc9);
      spin <= 1'b1;
      repeat (64) @(posedge sys_clk);
      spin <= 1'b0;
      frame(5'd0, 16'h0000, 8'hc9);
      frame(5'd3, 16'h0005, 8'h4d);
   endtask
   // Frame sent while frozen must be missed entirely
   task automatic sc_freeze();
      @(posedge sys_clk);
      clk_en <= 1'b0;
      start  <= 1'b1;
      nbits  <= 5'd0;
      @(posedge sys_clk);
      start  <= 1'b0;
      repeat (20) @(posedge sys_clk);
      clk_en <= 1'b1;
      repeat (8) @(negedge sys_clk);
      chk(8'h4d);
   endtask
   initial begin
      sc_reset();
      sc_words();
      sc_ignored();
      sc_freeze();
      sc_reset();
      test_done();
   end
endmodule
